// ### hw/irq_bank_pkg.sv
// Package: register map, field layout and reset values of the irq bank
package irq_bank_pkg;
    localparam int ADDR_W = 8; // Register address width
    localparam int DATA_W = 32; // Register data width
    localparam int LINES_LO = 32; // Lines 0 to 31
    localparam int LINES_HI = 18; // Lines 32 to 49
    // Byte offsets, chosen for this bank
    localparam logic [7:0] OFS_ENABLE_SET_LO = 8'h00;
    localparam logic [7:0] OFS_ENABLE_SET_HI = 8'h04;
    localparam logic [7:0] OFS_ENABLE_CLEAR_LO = 8'h08;
    localparam logic [7:0] OFS_ENABLE_CLEAR_HI = 8'h0C;
    localparam logic [7:0] OFS_PEND_SET_LO = 8'h10;
    localparam logic [7:0] OFS_PEND_SET_HI = 8'h14;
    localparam logic [7:0] OFS_PEND_CLEAR_LO = 8'h18;
    localparam logic [7:0] OFS_PEND_CLEAR_HI = 8'h1C;
    // Field positions of the high bank
    localparam int HI_FIELD_MSB = 17;
    localparam int HI_FIELD_LSB = 0;
    // Reset values
    localparam logic [31:0] ENABLE_LO_RST = 32'h0000_0000;
    localparam logic [17:0] ENABLE_HI_RST = 18'h0_0000;
    localparam logic [31:0] PEND_LO_RST = 32'h0000_0000;
    localparam logic [17:0] PEND_HI_RST = 18'h0_0000;
endpackage : irq_bank_pkg

// ### hw/irq_state_bits.sv
// Per-line enable/pending state with set and clear strobes
module irq_state_bits
    import irq_bank_pkg::*;
#(
    parameter int N = 32,
    parameter logic [N-1:0] RST_VAL = '0
)
(
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [N-1:0] set_bits, // Mask of set requests, any number of ones
    input wire logic [N-1:0] clr_bits, // Mask of clear requests, any number of ones
    output logic [N-1:0] state // Current state
);
    logic [N-1:0] state_reg; // Stored state
    logic [N-1:0] state_next; // Next state
    // Clear applied first so a set in the same cycle wins
    assign state_next = (state_reg & ~clr_bits) | set_bits;
    assign state = state_reg;

    // State update
    always_ff @(posedge clk)
    begin
        if (rst)
            state_reg <= RST_VAL;
        else
            state_reg <= state_next;
    end
endmodule : irq_state_bits

// ### hw/irq_enable_clear_pending_set.sv
// Enable and pending bank for interrupt lines 0 to 49
// What this block does
// - Clear-enable high bits 17:0 are lines 49:32
// - Writing one to clear-enable disables the line
// - Writing zero to clear-enable changes nothing
// - Clear-enable read returns current enable state
// - Set-pending low holds lines 0 to 31
// - Writing one pends enabled non-pending line only
// - Clear-pending clears; set-pending read shows pending
// - Set-enable shares enable state, one enables
//
// Overview for the next engineer:
// Each interrupt line owns one enable bit and one pending bit.
// Software never writes these bits directly; it writes masks of ones
// to a set word or a clear word, and zeros in a mask leave the bit
// alone. This is what lets several software threads touch different
// lines without a read-modify-write race on a shared word.
//
// The enable state is shared by the set and the clear banks, so both
// addresses read back the same live state.
//
// Limitations:
// - Bits 31:18 of every high word are not stored; they read as zero.
// - A pend request on a disabled line is dropped, not remembered, so
//   enabling the line later does not raise the old request.
// - The pending state has no defined reset value for software; zero
//   is used here so that simulation never starts with unknowns.
// - Unmapped addresses are silently ignored on write and read zero.
//
// Timing:
// - A write takes effect on the state at the edge that samples it.
// - Read data appear in the cycle after the read strobe, then return
//   to zero, so a bus that samples late sees zero, not stale data.
module irq_enable_clear_pending_set
    import irq_bank_pkg::*;
(
    input wire logic CLOCK, // 125 MHz system clock
    input wire logic RST, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] ADDR, // Register byte address
    input wire logic [DATA_W-1:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [DATA_W-1:0] RDATA, // Read data, cycle after strobe
    output logic [49:0] IRQ_ENABLE, // Enable state per line
    output logic [49:0] IRQ_PENDING // Pending state per line
);
    // Address match, shared by every write decode
    function automatic logic reg_hit
    (
        input logic [ADDR_W-1:0] a, // Address on the bus
        input logic [7:0] ofs // Offset of one register
    );
        return (a == ofs);
    endfunction : reg_hit

    // Zero pad of an 18-bit high field to a full data word
    function automatic logic [DATA_W-1:0] pad_hi
    (
        input logic [17:0] f // High field
    );
        return {14'h0, f};
    endfunction : pad_hi

    // Register decode: one strobe per writable word
    // Enable set, low and high word
    wire wr_en_set_lo = WR && reg_hit(ADDR, OFS_ENABLE_SET_LO);
    wire wr_en_set_hi = WR && reg_hit(ADDR, OFS_ENABLE_SET_HI);
    // Enable clear, low and high word
    wire wr_en_clr_lo = WR && reg_hit(ADDR, OFS_ENABLE_CLEAR_LO);
    wire wr_en_clr_hi = WR && reg_hit(ADDR, OFS_ENABLE_CLEAR_HI);
    // Pend set, low and high word
    wire wr_pd_set_lo = WR && reg_hit(ADDR, OFS_PEND_SET_LO);
    wire wr_pd_set_hi = WR && reg_hit(ADDR, OFS_PEND_SET_HI);
    // Pend clear, low and high word
    wire wr_pd_clr_lo = WR && reg_hit(ADDR, OFS_PEND_CLEAR_LO);
    wire wr_pd_clr_hi = WR && reg_hit(ADDR, OFS_PEND_CLEAR_HI);

    logic [31:0] enable_lo; // Enable state lines 0..31
    logic [17:0] enable_hi; // Enable state lines 32..49
    logic [31:0] pend_lo; // Pending state lines 0..31
    logic [17:0] pend_hi; // Pending state lines 32..49
    logic [DATA_W-1:0] rdata_reg; // Registered read data
    logic [DATA_W-1:0] rdata_next; // Read data to capture

    // Only the high field is kept; bits 31:18 never reach the state
    wire [17:0] wdata_hi = WDATA[HI_FIELD_MSB:HI_FIELD_LSB];

    // Ones enable, zeros ignored
    wire [31:0] enable_set_bits_lo =
        wr_en_set_lo ? WDATA : 32'h0000_0000;
    wire [17:0] enable_set_bits_hi =
        wr_en_set_hi ? wdata_hi : 18'h0_0000;
    // Ones disable, zeros ignored; bit n of the high word is line 32+n
    wire [31:0] enable_clear_bits_lo =
        wr_en_clr_lo ? WDATA : 32'h0000_0000;
    wire [17:0] enable_clear_bits_hi =
        wr_en_clr_hi ? wdata_hi : 18'h0_0000;

    // Pend only lines enabled and not yet pending
    wire [31:0] pend_set_bits_lo =
        wr_pd_set_lo ? (WDATA & enable_lo & ~pend_lo)
                     : 32'h0000_0000;
    wire [17:0] pend_set_bits_hi =
        wr_pd_set_hi ? (wdata_hi & enable_hi & ~pend_hi)
                     : 18'h0_0000;
    wire [31:0] pend_clear_bits_lo =
        wr_pd_clr_lo ? WDATA : 32'h0000_0000;
    wire [17:0] pend_clear_bits_hi =
        wr_pd_clr_hi ? wdata_hi : 18'h0_0000;

    // Enable state, shared by the set and clear banks
    irq_state_bits #(.N(32), .RST_VAL(ENABLE_LO_RST)) u_en_lo
    (
        .clk(CLOCK),
        .rst(RST),
        .set_bits(enable_set_bits_lo),
        .clr_bits(enable_clear_bits_lo),
        .state(enable_lo)
    );
    irq_state_bits #(.N(18), .RST_VAL(ENABLE_HI_RST)) u_en_hi
    (
        .clk(CLOCK),
        .rst(RST),
        .set_bits(enable_set_bits_hi),
        .clr_bits(enable_clear_bits_hi),
        .state(enable_hi)
    );
    // Pending state; reset value is left undefined by software, zero here
    irq_state_bits #(.N(32), .RST_VAL(PEND_LO_RST)) u_pd_lo
    (
        .clk(CLOCK),
        .rst(RST),
        .set_bits(pend_set_bits_lo),
        .clr_bits(pend_clear_bits_lo),
        .state(pend_lo)
    );
    irq_state_bits #(.N(18), .RST_VAL(PEND_HI_RST)) u_pd_hi
    (
        .clk(CLOCK),
        .rst(RST),
        .set_bits(pend_set_bits_hi),
        .clr_bits(pend_clear_bits_hi),
        .state(pend_hi)
    );

    // Read mux; unmapped addresses read zero, high words pad with zero
    always_comb
    begin
        case (ADDR)
            OFS_ENABLE_SET_LO, OFS_ENABLE_CLEAR_LO:
                rdata_next = enable_lo;
            OFS_ENABLE_SET_HI, OFS_ENABLE_CLEAR_HI:
                rdata_next = pad_hi(enable_hi);
            OFS_PEND_SET_LO, OFS_PEND_CLEAR_LO:
                rdata_next = pend_lo;
            OFS_PEND_SET_HI, OFS_PEND_CLEAR_HI:
                rdata_next = pad_hi(pend_hi);
            default:
                rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            rdata_reg <= 32'h0000_0000;
        else if (RD)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= 32'h0000_0000;
    end

    // Read data come straight from the flip-flop
    assign RDATA = rdata_reg;
    // Line n is bit n; the high bank sits above line 31
    assign IRQ_ENABLE = {enable_hi, enable_lo};
    // Pending view in the same line order as the enables
    assign IRQ_PENDING = {pend_hi, pend_lo};
endmodule : irq_enable_clear_pending_set

// ### tb/irq_bank_checker.sv
// Checker: port-level properties of the irq enable and pending bank
module irq_bank_checker
    import irq_bank_pkg::*;
(
    input wire logic CLOCK, // Clock
    input wire logic RST, // Reset
    input wire logic [ADDR_W-1:0] ADDR, // Address
    input wire logic [DATA_W-1:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    input wire logic [DATA_W-1:0] RDATA, // Read data
    input wire logic [49:0] IRQ_ENABLE, // Enable state
    input wire logic [49:0] IRQ_PENDING // Pending state
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, so one default clocking and disable
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    AST_CLR_HI: assert property (WR && ADDR == OFS_ENABLE_CLEAR_HI |=>
        IRQ_ENABLE[49:32] == ($past(IRQ_ENABLE[49:32]) & ~$past(WDATA[17:0])))
        else $error("clear-enable high write wrong");
    AST_SET_LO: assert property (WR && ADDR == OFS_ENABLE_SET_LO |=>
        IRQ_ENABLE[31:0] == ($past(IRQ_ENABLE[31:0]) | $past(WDATA)))
        else $error("set-enable low write wrong");
    AST_RD_HI: assert property (RD && ADDR == OFS_ENABLE_CLEAR_HI |=>
        RDATA == {14'h0, $past(IRQ_ENABLE[49:32])})
        else $error("clear-enable high read wrong");
    AST_PEND_SET: assert property (WR && ADDR == OFS_PEND_SET_LO |=>
        IRQ_PENDING[31:0] == ($past(IRQ_PENDING[31:0])
        | ($past(WDATA) & $past(IRQ_ENABLE[31:0]))))
        else $error("set-pending write wrong");
    AST_PEND_RD: assert property (RD && ADDR == OFS_PEND_SET_LO |=>
        RDATA == $past(IRQ_PENDING[31:0])) else $error("pending read wrong");
    AST_PEND_CLR: assert property (WR && ADDR == OFS_PEND_CLEAR_LO |=>
        IRQ_PENDING[31:0] == ($past(IRQ_PENDING[31:0]) & ~$past(WDATA)))
        else $error("clear-pending write wrong");
    AST_RD_IDLE: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data not zero");
    AST_HOLD: assert property (!WR |=> $stable(IRQ_ENABLE)
        && $stable(IRQ_PENDING)) else $error("state moved without write");
endmodule : irq_bank_checker
bind irq_enable_clear_pending_set irq_bank_checker i_irq_bank_checker (.CLOCK,
    .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ_ENABLE, .IRQ_PENDING);

// ### tb/testbench.sv
// Testbench: register-port scenarios for the irq bank
module testbench;
    import irq_bank_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK = 0, RST = 1, WR = 0, RD = 0; // Clock, reset, strobes
    logic [7:0] ADDR = 8'h00; // Address
    logic [31:0] WDATA = 32'h0, RDATA; // Data
    logic [49:0] IRQ_ENABLE, IRQ_PENDING; // State outputs
    int miscompares = 0, samples_checked = 0, cycles = 0; // Counters
    irq_enable_clear_pending_set i_irq_enable_clear_pending_set (.CLOCK,
        .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ_ENABLE, .IRQ_PENDING);
    initial forever #4 CLOCK = ~CLOCK;
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Ceiling well above the roughly 42 cycles the run needs
    always @(posedge CLOCK)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            test_done();
        end
    end
    task automatic chk(input logic [49:0] s, input logic [49:0] e);
        samples_checked++;
        if (s !== e)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        WR <= 1'b1; ADDR <= a; WDATA <= d;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLOCK);
        RD <= 1'b1; ADDR <= a;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1 chk(RDATA, e);
    endtask : rd
    // Upper enables: set all, clear two edge lines, upper bits ignored
    task automatic t_enable;
        wr(OFS_ENABLE_SET_HI, 32'hFFFFFFFF);
        rd(OFS_ENABLE_CLEAR_HI, 32'h0003FFFF);
        wr(OFS_ENABLE_CLEAR_HI, 32'hFFFE0001);
        rd(OFS_ENABLE_CLEAR_HI, 32'h0001FFFE);
        chk(IRQ_ENABLE, 50'h1FFFE00000000);
    endtask : t_enable
    // Pending only where enabled, then cleared by one bit
    task automatic t_pend;
        wr(OFS_ENABLE_SET_LO, 32'h0000FFFF);
        wr(OFS_PEND_SET_LO, 32'hFFFFFFFF);
        rd(OFS_PEND_SET_LO, 32'h0000FFFF);
        wr(OFS_PEND_CLEAR_LO, 32'h00000001);
        rd(OFS_PEND_SET_LO, 32'h0000FFFE);
        rd(8'h40, 32'h0);
        wr(OFS_PEND_SET_HI, 32'hFFFFFFFF);
        rd(OFS_PEND_SET_HI, 32'h0001FFFE);
        wr(OFS_PEND_SET_HI, 32'h00000001);
        wr(OFS_PEND_CLEAR_HI, 32'h00000002);
        rd(OFS_PEND_SET_HI, 32'h0001FFFC);
    endtask : t_pend
    initial
    begin
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        chk(IRQ_ENABLE | IRQ_PENDING, 50'h0);
        t_enable();
        t_pend();
        test_done();
    end
endmodule : testbench
